// ### rtl/lcdsc_map.svh
// Register map, field positions, reset values and timing counts for the
// segment display control block. Assumes a 32-bit classic Wishbone slave.
`ifndef LCDSC_MAP_SVH
`define LCDSC_MAP_SVH

`define LCDSC_ADR_CMD      4'h0
`define LCDSC_ADR_CR0      4'h1
`define LCDSC_ADR_CR1      4'h2
`define LCDSC_ADR_CLKS     4'h3
`define LCDSC_ADR_SUPPLY   4'h4
`define LCDSC_ADR_BCTL     4'h5
`define LCDSC_ADR_FPEN_LO  4'h6
`define LCDSC_ADR_FPEN_HI  4'h7
`define LCDSC_ADR_MASK     4'h8

`define LCDSC_NUM_FP       41
`define LCDSC_FP_HI_W      9
`define LCDSC_NUM_BP       4

// Control register zero: enable[7], rate[5:3], low_power_waveform_select[2], duty[1:0]
`define LCDSC_CR0_EN       7
`define LCDSC_CR0_LPW      2
`define LCDSC_CR0_RST      8'h03
// Control register one: irq enable[7], wait off[1], stop off[0]
`define LCDSC_CR1_IEN      7
`define LCDSC_CR1_RST      8'h00
`define LCDSC_CLKS_RST     8'h00
// Supply: pump en[7], pms[6], hdrv[5], pump_clock_adjust[4:3], bypass[2], supply_source_select[1:0]
`define LCDSC_SUP_PUMP     7
`define LCDSC_SUP_VS1      1
`define LCDSC_SUP_RST      8'h03
`define LCDSC_BCTL_RST     8'h00
`define LCDSC_BIAS_THIRD   2'h2
`define LCDSC_DUTY_QUARTER 2'h3

// Base frame divider from the 10 MHz system clock; frame = base << rate
`define LCDSC_CLK_HZ       10000000
`define LCDSC_BASE_HZ      2560
`define LCDSC_BASE_DIV     (`LCDSC_CLK_HZ / `LCDSC_BASE_HZ)
`endif

// ### rtl/lcdsc_pkg.sv
// Types shared by the segment display control block.
// Assumes the map header supplies the numbers.
package lcdsc_pkg;
    typedef enum logic [1:0]
    {
        LCDSC_SUP_VDD_LL2 = 2'b00,
        LCDSC_SUP_VDD_LL3 = 2'b01,
        LCDSC_SUP_EXT_LCD = 2'b10,
        LCDSC_SUP_EXT_ALL = 2'b11
    } lcdsc_supply_t;
    typedef enum logic [1:0]
    {
        LCDSC_PH_IDLE  = 2'b00,
        LCDSC_PH_FIRST = 2'b01,
        LCDSC_PH_SECND = 2'b10
    } lcdsc_phase_t;
endpackage

// ### rtl/lcdsc_framer.sv
// Frame and sub-frame tick generator.
// Assumes one system clock; frame length set by the rate field.
`timescale 1ns/1ns
`default_nettype none
`include "lcdsc_map.svh"
module lcdsc_framer
    import lcdsc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic [2:0] rate_i,
    input  wire logic       low_power_waveform_select_i,
    output logic            event_o,
    output logic            phase_o
);
    logic [22:0]  cnt_r;
    logic [22:0]  cnt_nxt;
    lcdsc_phase_t ph_r;
    lcdsc_phase_t ph_nxt;
    logic         ev_nxt;
    logic [22:0]  half_len;

    // Half frame; a whole frame is two halves in either waveform
    assign half_len = 23'((`LCDSC_BASE_DIV / 2) << rate_i);
    assign phase_o  = (ph_r == LCDSC_PH_SECND);

    always_comb
    begin
        cnt_nxt = cnt_r;
        ph_nxt  = ph_r;
        ev_nxt  = 1'b0;
        case (ph_r)
            LCDSC_PH_IDLE:
            begin
                cnt_nxt = 23'h0;
                if (run_i)
                    ph_nxt = LCDSC_PH_FIRST;
            end
            LCDSC_PH_FIRST:
            begin
                cnt_nxt = cnt_r + 23'h1;
                if (cnt_r >= half_len - 23'h1)
                begin
                    cnt_nxt = 23'h0;
                    ph_nxt  = LCDSC_PH_SECND;
                    ev_nxt  = low_power_waveform_select_i;
                end
            end
            LCDSC_PH_SECND:
            begin
                cnt_nxt = cnt_r + 23'h1;
                if (cnt_r >= half_len - 23'h1)
                begin
                    cnt_nxt = 23'h0;
                    ph_nxt  = LCDSC_PH_FIRST;
                    // frame end, same length both modes
                    ev_nxt  = 1'b1;
                end
            end
            default:
                ph_nxt = LCDSC_PH_IDLE;
        endcase
        if (!run_i)
        begin
            ph_nxt  = LCDSC_PH_IDLE;
            cnt_nxt = 23'h0;
            ev_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r   <= 23'h0;
            ph_r    <= LCDSC_PH_IDLE;
            event_o <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            ph_r    <= ph_nxt;
            event_o <= ev_nxt;
        end
    end

    frame_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        event_o && !low_power_waveform_select_i |=> !event_o [*8])
        else $error("frame events too close");
endmodule
`default_nettype wire

// ### rtl/lcdsc_top.sv
// Segment display control: registers, frame event flag, interrupt and
// electrode driver enables. Assumes a classic Wishbone master on CLK_SYS_I.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "lcdsc_map.svh"
module lcdsc_top
    import lcdsc_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [5:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             IRQ_O,
    output logic [40:0]      FP_OE_O,
    output logic [40:0]      FP_LVL_O,
    output logic [3:0]       BP_OE_O,
    output logic [3:0]       BP_LVL_O,
    output logic             INT_SUPPLY_O,
    output logic             PUMP_EN_O,
    output logic [1:0]       BIAS_O,
    output logic [1:0]       DUTY_O
);
    logic [7:0]  cr0_r, cr0_nxt;
    logic [7:0]  cr1_r, cr1_nxt;
    logic [7:0]  clks_r, clks_nxt;
    logic [7:0]  sup_r, sup_nxt;
    logic [7:0]  bctl_r, bctl_nxt;
    logic [40:0] fpen_r, fpen_nxt;
    logic        flag_r, flag_nxt;
    logic        mask_r, mask_nxt;
    logic        ack_nxt;
    logic [31:0] dat_nxt;
    logic        irq_nxt;
    logic        req;
    logic        wr;
    logic [3:0]  idx;
    logic        frame_ev;
    logic        phase;
    logic        enabled;
    logic [40:0] fp_oe_nxt;
    logic [40:0] fp_lvl_nxt;
    logic [22:0] half_len;
    logic [22:0] exp_len;
    logic [22:0] gap_r, gap_nxt;
    logic        seen_r, seen_nxt;

    // Words are aligned; low two address bits are ignored
    assign idx     = WB_ADR_I[5:2];
    assign req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr      = req && WB_WE_I && WB_SEL_I[0];
    assign enabled = cr0_r[`LCDSC_CR0_EN];

    lcdsc_framer u_framer
    (
        .clk_i    (CLK_SYS_I),
        .rst_n_i  (RST_N_I),
        .run_i    (enabled),
        .rate_i   (cr0_r[5:3]),
        .low_power_waveform_select_i (cr0_r[`LCDSC_CR0_LPW]),
        .event_o  (frame_ev),
        .phase_o  (phase)
    );

    // =====================================================
    // Register writes
    always_comb
    begin
        cr0_nxt  = cr0_r;
        cr1_nxt  = cr1_r;
        clks_nxt = clks_r;
        sup_nxt  = sup_r;
        bctl_nxt = bctl_r;
        fpen_nxt = fpen_r;
        mask_nxt = mask_r;
        flag_nxt = flag_r;
        if (wr)
        begin
            if (idx == `LCDSC_ADR_CMD)
            begin
                if (WB_DAT_I[0])
                    flag_nxt = 1'b0;
            end
            else if (idx == `LCDSC_ADR_CR0)
                cr0_nxt = WB_DAT_I[7:0];
            else if (idx == `LCDSC_ADR_CR1)
            begin
                cr1_nxt  = WB_DAT_I[7:0];
                mask_nxt = WB_DAT_I[`LCDSC_CR1_IEN];
            end
            else if (idx == `LCDSC_ADR_CLKS)
                clks_nxt = WB_DAT_I[7:0];
            else if (idx == `LCDSC_ADR_SUPPLY)
                sup_nxt = WB_DAT_I[7:0];
            else if (idx == `LCDSC_ADR_BCTL)
                bctl_nxt = WB_DAT_I[7:0];
            else if (idx == `LCDSC_ADR_FPEN_LO)
                fpen_nxt[31:0] = WB_DAT_I;
            else if (idx == `LCDSC_ADR_FPEN_HI)
                fpen_nxt[40:32] = WB_DAT_I[`LCDSC_FP_HI_W-1:0];
            else if (idx == `LCDSC_ADR_MASK)
            begin
                mask_nxt = WB_DAT_I[0];
                cr1_nxt[`LCDSC_CR1_IEN] = WB_DAT_I[0];
            end
        end
        // a new event wins over a clear
        if (frame_ev)
            flag_nxt = 1'b1;
    end

    // =====================================================
    // Read mux and acknowledge
    always_comb
    begin
        dat_nxt = 32'h0;
        ack_nxt = req;
        if (idx == `LCDSC_ADR_CMD)
            dat_nxt = {31'h0, flag_r};
        else if (idx == `LCDSC_ADR_CR0)
            dat_nxt = {24'h0, cr0_r};
        else if (idx == `LCDSC_ADR_CR1)
            dat_nxt = {24'h0, cr1_r};
        else if (idx == `LCDSC_ADR_CLKS)
            dat_nxt = {24'h0, clks_r};
        else if (idx == `LCDSC_ADR_SUPPLY)
            dat_nxt = {24'h0, sup_r};
        else if (idx == `LCDSC_ADR_BCTL)
            dat_nxt = {24'h0, bctl_r};
        else if (idx == `LCDSC_ADR_FPEN_LO)
            dat_nxt = fpen_r[31:0];
        else if (idx == `LCDSC_ADR_FPEN_HI)
            dat_nxt = {23'h0, fpen_r[40:32]};
        else if (idx == `LCDSC_ADR_MASK)
            dat_nxt = {31'h0, mask_r};
        if (!req)
            dat_nxt = 32'h0;
        irq_nxt = flag_nxt && mask_nxt;
    end

    // =====================================================
    // Electrode drive
    genvar g;
    generate
        for (g = 0; g < `LCDSC_NUM_FP; g = g + 1)
        begin : g_fp
            assign fp_oe_nxt[g]  = enabled && fpen_r[g];
            assign fp_lvl_nxt[g] = fp_oe_nxt[g] && (phase ^ 1'(g % 2));
        end
    endgenerate

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            cr0_r        <= `LCDSC_CR0_RST;
            cr1_r        <= `LCDSC_CR1_RST;
            clks_r       <= `LCDSC_CLKS_RST;
            sup_r        <= `LCDSC_SUP_RST;
            bctl_r       <= `LCDSC_BCTL_RST;
            fpen_r       <= 41'h0;
            flag_r       <= 1'b0;
            mask_r       <= 1'b0;
            WB_ACK_O     <= 1'b0;
            WB_DAT_O     <= 32'h0;
            IRQ_O        <= 1'b0;
            FP_OE_O      <= 41'h0;
            FP_LVL_O     <= 41'h0;
            BP_OE_O      <= 4'h0;
            BP_LVL_O     <= 4'h0;
            INT_SUPPLY_O <= 1'b0;
            PUMP_EN_O    <= 1'b0;
            BIAS_O       <= `LCDSC_BIAS_THIRD;
            DUTY_O       <= `LCDSC_DUTY_QUARTER;
        end
        else
        begin
            cr0_r        <= cr0_nxt;
            cr1_r        <= cr1_nxt;
            clks_r       <= clks_nxt;
            sup_r        <= sup_nxt;
            bctl_r       <= bctl_nxt;
            fpen_r       <= fpen_nxt;
            flag_r       <= flag_nxt;
            mask_r       <= mask_nxt;
            WB_ACK_O     <= ack_nxt;
            WB_DAT_O     <= dat_nxt;
            IRQ_O        <= irq_nxt;
            FP_OE_O      <= fp_oe_nxt;
            FP_LVL_O     <= fp_lvl_nxt;
            BP_OE_O      <= {`LCDSC_NUM_BP{enabled}};
            BP_LVL_O     <= {`LCDSC_NUM_BP{enabled && phase}};
            // internal only for codes 00 and 01
            INT_SUPPLY_O <= !sup_r[`LCDSC_SUP_VS1];
            PUMP_EN_O    <= sup_r[`LCDSC_SUP_PUMP];
            BIAS_O       <= `LCDSC_BIAS_THIRD;
            DUTY_O       <= cr0_r[1:0];
        end
    end

    // =====================================================
    // Frame length monitor
    // Counts cycles between events; a write to control zero restarts the
    // measurement, since a frame in flight would then mix two settings.
    // Helper state only, read by the checks below and nothing else.
    always_comb
    begin
        half_len = 23'((`LCDSC_BASE_DIV / 2) << cr0_r[5:3]);
        exp_len  = {half_len[21:0], 1'b0};
        if (cr0_r[`LCDSC_CR0_LPW])
            exp_len = half_len;
        gap_nxt  = gap_r + 23'h1;
        seen_nxt = seen_r;
        if (frame_ev)
        begin
            gap_nxt  = 23'h1;
            seen_nxt = 1'b1;
        end
        if (!enabled || (wr && idx == `LCDSC_ADR_CR0))
        begin
            gap_nxt  = 23'h0;
            seen_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            gap_r  <= 23'h0;
            seen_r <= 1'b0;
        end
        else
        begin
            gap_r  <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end

    // =====================================================
    // Checks
    supply_sel_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        ##1 INT_SUPPLY_O == !$past(sup_r[`LCDSC_SUP_VS1]))
        else $error("supply source mismatch");
    ext_supply_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        sup_r[`LCDSC_SUP_VS1] ##1 sup_r[`LCDSC_SUP_VS1] |-> !INT_SUPPLY_O)
        else $error("external supply drew core");
    hiz_off_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !enabled ##1 !enabled |-> FP_OE_O == 41'h0 && BP_OE_O == 4'h0)
        else $error("drivers on while disabled");
    reset_def_a: assert property (@(posedge CLK_SYS_I)
        !RST_N_I |=> DUTY_O == `LCDSC_DUTY_QUARTER && BIAS_O == `LCDSC_BIAS_THIRD)
        else $error("reset duty or bias wrong");
    fp_clear_a: assert property (@(posedge CLK_SYS_I)
        !RST_N_I |=> fpen_r == 41'h0)
        else $error("frontplane enables survive reset");
    reset_fields_a: assert property (@(posedge CLK_SYS_I)
        !RST_N_I |=> sup_r == `LCDSC_SUP_RST && bctl_r == `LCDSC_BCTL_RST
                     && cr0_r == `LCDSC_CR0_RST)
        else $error("fields not at reset value");
    flag_set_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        frame_ev |=> flag_r)
        else $error("event did not set flag");
    flag_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        flag_r && !(wr && idx == `LCDSC_ADR_CMD && WB_DAT_I[0]) |=> flag_r)
        else $error("flag dropped without clear");
    irq_level_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        IRQ_O == (flag_r && cr1_r[`LCDSC_CR1_IEN]))
        else $error("irq not flag and enable");
    fp_drive_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        ##1 FP_OE_O == ($past(fpen_r) & {41{$past(enabled)}}))
        else $error("frontplane enable mismatch");
    clear_race_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        frame_ev && wr && idx == `LCDSC_ADR_CMD |=> flag_r)
        else $error("event lost to clear");
    frame_len_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        frame_ev && seen_r |-> gap_r == exp_len)
        else $error("frame or sub-frame length wrong");
    lvl_undriven_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (FP_LVL_O & ~FP_OE_O) == 41'h0 && (BP_LVL_O & ~BP_OE_O) == 4'h0)
        else $error("level on undriven electrode");
    clear_works_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        wr && idx == `LCDSC_ADR_CMD && WB_DAT_I[0] && !frame_ev |=> !flag_r)
        else $error("write one did not clear flag");
    ev_idle_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !enabled ##1 !enabled |-> !frame_ev)
        else $error("event while display disabled");

    irq_seen_c: cover property (@(posedge CLK_SYS_I) IRQ_O);
    lp_event_c: cover property (@(posedge CLK_SYS_I)
        frame_ev && cr0_r[`LCDSC_CR0_LPW]);
    clear_c: cover property (@(posedge CLK_SYS_I) flag_r ##1 !flag_r);
    race_c: cover property (@(posedge CLK_SYS_I)
        frame_ev && wr && idx == `LCDSC_ADR_CMD);
endmodule
`default_nettype wire

// ### verification/lcdsc_glass_model.sv
// Passive segment glass model: resolves the level on each electrode pad.
// Assumes driver enables and levels come straight from the control block.
`timescale 1ns/1ns
`default_nettype none
module lcdsc_glass_model
(
    input  wire logic        clk_i,
    input  wire logic [40:0] fp_oe_i,
    input  wire logic [40:0] fp_lvl_i,
    input  wire logic [3:0]  bp_oe_i,
    input  wire logic [3:0]  bp_lvl_i,
    output logic      [40:0] fp_pad_o,
    output logic      [3:0]  bp_pad_o
);
    logic float_r = 1'b0;

    // A floating pad toggles so it never passes for a steady 0 or 1
    always @(posedge clk_i)
        float_r <= ~float_r;

    always_comb
    begin
        for (int i = 0; i < 41; i++)
            fp_pad_o[i] = fp_oe_i[i] ? fp_lvl_i[i] : float_r;
        for (int i = 0; i < 4; i++)
            bp_pad_o[i] = bp_oe_i[i] ? bp_lvl_i[i] : float_r;
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the segment display control block.
// Assumes the registers on classic Wishbone and a glass model on the pads.
`timescale 1ns/1ns
`default_nettype none
`include "lcdsc_map.svh"
module tb_top
    import lcdsc_pkg::*;
;
    localparam int FRAME = `LCDSC_BASE_DIV;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic [40:0] fp_oe;
    logic [40:0] fp_lvl;
    logic [40:0] fp_pad;
    logic [3:0]  bp_oe;
    logic [3:0]  bp_lvl;
    logic [3:0]  bp_pad;
    logic        int_sup;
    logic        pump;
    logic [1:0]  bias;
    logic [1:0]  duty;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #50 clk = ~clk;
    always @(posedge clk)
        cycles <= cycles + 1;

    lcdsc_top u_dut
    (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq), .FP_OE_O(fp_oe),
        .FP_LVL_O(fp_lvl), .BP_OE_O(bp_oe), .BP_LVL_O(bp_lvl),
        .INT_SUPPLY_O(int_sup), .PUMP_EN_O(pump), .BIAS_O(bias), .DUTY_O(duty)
    );

    lcdsc_glass_model u_glass
    (
        .clk_i(clk), .fp_oe_i(fp_oe), .fp_lvl_i(fp_lvl), .bp_oe_i(bp_oe),
        .bp_lvl_i(bp_lvl), .fp_pad_o(fp_pad), .bp_pad_o(bp_pad)
    );

    // ==========================================================
    // Compare, bus and closing tasks
    task automatic chk(input logic [40:0] got, input logic [40:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("TB: errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Holds the request until ack is sampled; a missing ack counts as a fault
    task automatic wb_xfer(input logic w, input logic [3:0] idx, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'hf;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        chk(41'(ack), 41'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, idx, 32'h0, q);
        chk(41'(q), 41'(exp));
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (irq !== 1'b1 && n < 3 * FRAME);
        chk(41'(irq), 41'h1); // event arrives
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk(fp_oe, 41'h0); // frontplanes off
        chk(41'(bp_oe), 41'h0); // backplanes off
        chk(41'(bias), 41'(`LCDSC_BIAS_THIRD)); // third bias
        chk(41'(duty), 41'(`LCDSC_DUTY_QUARTER)); // quarter duty
        chk(41'(int_sup), 41'h0); // external at reset
        chk(fp_lvl, 41'h0); // no level while off
        chk(41'(bp_lvl), 41'h0); // no level while off
        chk(41'(pump), 41'h0); // supply field default
        chk(41'(irq), 41'h0); // no request after reset
        rd_chk(`LCDSC_ADR_CR0, 32'h03); // control default
        rd_chk(`LCDSC_ADR_SUPPLY, 32'h03); // supply default
        rd_chk(`LCDSC_ADR_BCTL, 32'h00); // blink default
        rd_chk(`LCDSC_ADR_FPEN_LO, 32'h0); // enables cleared
        rd_chk(`LCDSC_ADR_FPEN_HI, 32'h0); // enables cleared
        rd_chk(4'h9, 32'h0);
    endtask

    task automatic t_supply();
        logic [31:0] v;
        wr(`LCDSC_ADR_CLKS, 32'h0); // clock first
        for (int c = 0; c < 4; c++)
        begin
            v = 32'h80 | 32'(c);
            wr(`LCDSC_ADR_SUPPLY, v); // pump on, 3-V glass
            settle();
            chk(41'(int_sup), 41'(c < 2)); // supply source
            chk(41'(pump), 41'h1); // pump follows
            rd_chk(`LCDSC_ADR_SUPPLY, v); // supply field
        end
    endtask

    task automatic t_fp();
        wr(`LCDSC_ADR_FPEN_LO, 32'ha5a5a5a5);
        wr(`LCDSC_ADR_FPEN_HI, 32'h155);
        settle();
        chk(fp_oe, 41'h0); // idle until display on
        wr(`LCDSC_ADR_CR0, 32'h83); // display enable last
        settle();
        chk(fp_oe, {9'h155, 32'ha5a5a5a5}); // per-bit enables
        chk(fp_pad & fp_oe, fp_lvl & fp_oe); // waveform on pads
        chk(41'(bp_oe), 41'hf); // backplanes driven
        chk(fp_lvl & ~fp_oe, 41'h0); // no level where disabled
        chk(41'(bp_pad), 41'(bp_lvl)); // backplane pads driven
    endtask

    task automatic t_frame(input logic lpw, input int exp_gap);
        int t0;
        wr(`LCDSC_ADR_CR1, 32'h80);
        wr(`LCDSC_ADR_CR0, 32'h83 | (32'(lpw) << 2));
        wr(`LCDSC_ADR_CMD, 32'h1);
        settle();
        wait_irq();
        t0 = cycles;
        repeat (5) @(posedge clk);
        chk(41'(irq), 41'h1); // flag holds
        wr(`LCDSC_ADR_CMD, 32'h0);
        rd_chk(`LCDSC_ADR_CMD, 32'h1); // zero write ignored
        wr(`LCDSC_ADR_CR1, 32'h0);
        settle();
        chk(41'(irq), 41'h0); // masked
        wr(`LCDSC_ADR_CR1, 32'h80);
        settle();
        chk(41'(irq), 41'h1); // unmasked
        wr(`LCDSC_ADR_CMD, 32'h1);
        settle();
        chk(41'(irq), 41'h0); // write one clears
        wait_irq();
        chk_cnt(cycles - t0, exp_gap); // event spacing
        // Irq is seen two edges after the event; aim the clear at the next one
        repeat (exp_gap - 3) @(posedge clk);
        wr(`LCDSC_ADR_CMD, 32'h1); // clear meets event
        rd_chk(`LCDSC_ADR_CMD, 32'h1); // event beats clear
    endtask

    task automatic t_rerst();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset(); // defaults after a live reset
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_supply();
        t_fp();
        t_frame(1'b0, FRAME); // once per frame
        t_frame(1'b1, FRAME / 2); // two equal sub-frames
        t_rerst(); // reset in mid-run
        complete_run();
    end

    // Whole run is near 18k cycles; this leaves ample margin
    initial
    begin
        #6000000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
